// file: design/lpc_pkg.sv
// Shared constants and types of the line printer controller
package lpc_pkg;
    // Host instruction word: operation, device group, unit number
    localparam int INS_OP_HI   = 15;
    localparam int INS_OP_LO   = 10;
    localparam int INS_GRP_HI  = 9;
    localparam int INS_GRP_LO  = 8;
    localparam int INS_UNIT_HI = 3;
    localparam int INS_UNIT_LO = 0;
    localparam logic [5:0] OP_COMMAND = 6'h10;
    localparam logic [5:0] OP_DATA    = 6'h11;
    localparam logic [5:0] OP_STATUS  = 6'h12;
    localparam logic [1:0] OWN_GROUP  = 2'h0;
    localparam logic [3:0] OWN_UNIT   = 4'h7;

    // Command word held in the host source register
    localparam int CMD_SEL_HI  = 15;
    localparam int CMD_SEL_LO  = 14;
    localparam int CMD_DI      = 13;
    localparam int CMD_SI      = 12;
    localparam int CMD_EOB     = 11;
    localparam int CMD_TERM    = 10;
    localparam int CMD_MOVE    = 9;
    localparam int FEED_HI     = 6;
    localparam int FEED_LO     = 0;
    localparam int FEED_SKIP   = 6;
    localparam int CHAN_HI     = 2;
    localparam int LINES_HI    = 5;
    localparam logic [1:0] SEL_TERM = 2'h0;
    localparam logic [1:0] SEL_NOOP = 2'h1;
    localparam logic [1:0] SEL_XFER = 2'h2;
    localparam logic [1:0] SEL_CTRL = 2'h3;

    // Character data and line buffer
    localparam int CHAR_W     = 7;
    localparam int FIFO_DEPTH = 32;
    localparam int COL_W      = 8;
    localparam logic [COL_W-1:0] COL_MAX = 8'h84;

    // Data strobe pacing, in clock cycles after a character is taken
    localparam logic [3:0] STB_AT   = 4'h4;
    localparam logic [3:0] STB_DONE = 4'h8;

    // Status word positions (bit 15 is the most significant)
    localparam int STS_OK      = 15;
    localparam int STS_INOP    = 12;
    localparam int STS_BUSY    = 8;
    localparam int STS_BUFBUSY = 7;
    localparam int STS_PLOW    = 6;
    localparam int STS_BOF     = 5;
    localparam int STS_HOLD    = 3;

    // Printer pins, in the order of the synchroniser
    localparam int PIN_READY = 0;
    localparam int PIN_SEND  = 1;
    localparam int PIN_POWER = 2;
    localparam int PIN_STOP  = 3;
    localparam int PIN_PLOW  = 4;
    localparam int PIN_BOF   = 5;
    localparam int PIN_N     = 6;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FEED  = 3'b001,
        ST_LOAD  = 3'b010,
        ST_FLUSH = 3'b011,
        ST_PRINT = 3'b100
    } lpc_state_e;
endpackage : lpc_pkg

// file: design/lpc_fifo_if.sv
// Carrier between the controller core and its character buffer
`timescale 1ns/1ns
interface lpc_fifo_if #(parameter int W = 7);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    modport ctl  (output push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data);
    modport fifo (input  push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
endinterface : lpc_fifo_if

// file: design/lpc_fifo.sv
// Character buffer between host data writes and the printer strobe
`timescale 1ns/1ns
module lpc_fifo #(
    parameter int W     = 7,
    parameter int DEPTH = 32
) (
    input wire logic clk,   // 20 MHz clock
    input wire logic reset, // Asynchronous, active high
    lpc_fifo_if.fifo f      // Push and pop sides
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } lpc_fifo_s;

    lpc_fifo_s q;
    lpc_fifo_s d;
    logic      push;
    logic      pop;

    assign f.push_ready = (q.cnt != (AW+1)'(DEPTH));
    assign f.pop_valid  = (q.cnt != '0);
    assign f.pop_data   = q.mem[q.rd];
    assign push         = f.push_valid & f.push_ready;
    assign pop          = f.pop_valid & f.pop_ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = f.push_data;
            d.wr        = q.wr + AW'(1);
        end
        if (pop)
        begin
            d.rd = q.rd + AW'(1);
        end
        if (push && !pop)
        begin
            d.cnt = q.cnt + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            d.cnt = q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule : lpc_fifo

// file: design/lpc_top.sv
// Line printer controller: host instruction decode, paper and print sequencing
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module lpc_top
    import lpc_pkg::*;
(
    input  wire logic               clk,                  // 20 MHz clock
    input  wire logic               reset,                // Asynchronous, active high
    input  wire logic               io_sync,              // Instruction strobe, one cycle
    input  wire logic [15:0]        io_instr,             // Host instruction word
    input  wire logic [15:0]        host_source_register, // Contents of named register
    output logic      [15:0]        status_word,          // Status for input-status
    output logic                    status_valid,         // Status word valid pulse
    output logic                    data_irq,             // Data interrupt request
    output logic                    svc_irq,              // Service interrupt request
    input  wire logic               prn_ready,            // Printer ready pin
    input  wire logic               prn_send_data,        // Printer accepts data pin
    input  wire logic               prn_power_on,         // Printer power on pin
    input  wire logic               prn_stopped,          // Stop button state pin
    input  wire logic               prn_paper_low,        // Paper low pin
    input  wire logic               prn_bottom_form,      // Bottom of form pin
    output logic                    paper_feed_cmd,       // Paper feed command
    output logic                    feed_skip,            // Skip to channel, else lines
    output logic      [5:0]         feed_lines,           // Lines to advance
    output logic      [7:0]         feed_channel,         // One-hot format channel
    output logic                    print_cmd,            // Load; falling edge prints
    output logic                    data_strobe,          // Character strobe pulse
    output logic      [CHAR_W-1:0]  char_out              // Character to printer
);
    import lpc_pkg::*;

    typedef struct packed {
        logic [PIN_N-1:0]  sync1;
        logic [PIN_N-1:0]  sync2;
        lpc_state_e        st;
        logic              seen_busy;
        logic              is_xfer;
        logic              di_conn;
        logic              si_conn;
        logic              di_pend;
        logic              si_pend;
        logic              inop_latch;
        logic              held;
        logic [15:0]       held_cmd;
        logic [COL_W-1:0]  cols;
        logic              term;
        logic              dready;
        logic              stb_act;
        logic [3:0]        stb_cnt;
        logic [15:0]       status;
        logic              status_valid;
        logic              pfd;
        logic              skip;
        logic [5:0]        lines;
        logic [7:0]        chan;
        logic              prt;
        logic              stb;
        logic [CHAR_W-1:0] chr;
        logic              data_irq;
        logic              svc_irq;
    } lpc_state_s;

    lpc_state_s q;
    lpc_state_s d;

    lpc_fifo_if #(.W(CHAR_W)) buf_if ();

    lpc_fifo #(
        .W     (CHAR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .reset (reset),
        .f     (buf_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode, printer pin view, buffer handshakes
    logic       addr_hit;
    logic       cmd_hit;
    logic       data_hit;
    logic       stat_hit;
    logic [1:0] cmd_sel;
    logic       hold;
    logic       inop;
    logic       ready_s;
    logic       send_s;
    logic       loading;
    logic       draining;

    assign addr_hit = io_sync
                    && (io_instr[INS_GRP_HI:INS_GRP_LO] == OWN_GROUP)
                    && (io_instr[INS_UNIT_HI:INS_UNIT_LO] == OWN_UNIT);
    assign cmd_hit  = addr_hit && (io_instr[INS_OP_HI:INS_OP_LO] == OP_COMMAND);
    assign data_hit = addr_hit && (io_instr[INS_OP_HI:INS_OP_LO] == OP_DATA);
    assign stat_hit = addr_hit && (io_instr[INS_OP_HI:INS_OP_LO] == OP_STATUS);
    assign cmd_sel  = host_source_register[CMD_SEL_HI:CMD_SEL_LO];

    assign ready_s  = q.sync2[PIN_READY];
    assign send_s   = q.sync2[PIN_SEND];
    assign inop     = !q.sync2[PIN_POWER];
    assign hold     = q.sync2[PIN_POWER] && q.sync2[PIN_STOP];

    // Loading window: column limit and terminate both close it
    assign loading  = (q.st == ST_LOAD) && !q.term && (q.cols != COL_MAX);
    assign draining = (q.st == ST_LOAD) || (q.st == ST_FLUSH);

    // Words arrive only from data-out; a full buffer refuses them
    assign buf_if.push_valid = data_hit && loading;
    assign buf_if.push_data  = host_source_register[CHAR_W-1:0];
    assign buf_if.pop_ready  = draining && !q.stb_act && send_s;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic si_set;
        logic di_set;
        logic [6:0] field;
        si_set = 1'b0;
        di_set = 1'b0;
        field  = q.held_cmd[FEED_HI:FEED_LO];
        d      = q;
        d.status_valid = 1'b0;

        // Printer pins are asynchronous; second stage is the only reader
        d.sync1 = {prn_bottom_form, prn_paper_low, prn_stopped,
                   prn_power_on, prn_send_data, prn_ready};
        d.sync2 = q.sync1;

        // A data-out acknowledges the pending data request
        d.di_pend = q.di_pend && !data_hit;

        if (cmd_hit)
        begin
            if (cmd_sel != SEL_TERM)
            begin
                d.di_conn = host_source_register[CMD_DI];
                d.si_conn = host_source_register[CMD_SI];
                d.di_pend = d.di_pend && host_source_register[CMD_DI];
                d.si_pend = d.si_pend && host_source_register[CMD_SI];
            end
            unique case (cmd_sel)
                SEL_NOOP:
                begin
                    d.di_pend    = 1'b0;
                    d.si_pend    = 1'b0;
                    d.inop_latch = 1'b0;
                end
                SEL_XFER, SEL_CTRL:
                begin
                    if (cmd_sel == SEL_XFER || host_source_register[CMD_MOVE])
                    begin
                        if (inop)
                        begin
                            d.inop_latch = 1'b1;
                            si_set       = 1'b1;
                        end
                        else if (q.st == ST_IDLE && !q.held)
                        begin
                            // Stored here, launched once the printer is in run
                            d.held     = 1'b1;
                            d.held_cmd = host_source_register;
                        end
                    end
                end
                SEL_TERM:
                begin
                    di_set = host_source_register[CMD_EOB];
                    if (host_source_register[CMD_TERM])
                    begin
                        d.term    = 1'b1;
                        d.di_pend = 1'b0;
                        if (q.st == ST_IDLE && !q.held)
                        begin
                            si_set = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Sequencer
        unique case (q.st)
            ST_IDLE:
            begin
                if (q.held && !hold)
                begin
                    d.held      = 1'b0;
                    d.is_xfer   = (q.held_cmd[CMD_SEL_HI:CMD_SEL_LO] == SEL_XFER);
                    d.skip      = field[FEED_SKIP];
                    d.lines     = field[FEED_SKIP] ? 6'h00 : field[LINES_HI:0];
                    d.chan      = field[FEED_SKIP] ? 8'h01 << field[CHAN_HI:0]
                                                   : 8'h00;
                    d.pfd       = 1'b1;
                    d.seen_busy = 1'b0;
                    d.cols      = '0;
                    d.term      = 1'b0;
                    d.st        = ST_FEED;
                end
            end
            ST_FEED:
            begin
                if (!ready_s)
                begin
                    d.seen_busy = 1'b1;
                    d.pfd       = 1'b0;
                end
                if (q.seen_busy && ready_s)
                begin
                    if (q.is_xfer)
                    begin
                        d.prt = 1'b1;
                        d.st  = ST_LOAD;
                    end
                    else
                    begin
                        si_set = 1'b1;
                        d.st   = ST_IDLE;
                    end
                end
            end
            ST_LOAD:
            begin
                if (buf_if.push_valid && buf_if.push_ready)
                begin
                    d.cols = q.cols + COL_W'(1);
                end
                if (q.term || q.cols == COL_MAX)
                begin
                    d.st = ST_FLUSH;
                end
            end
            ST_FLUSH:
            begin
                // Print only after the last strobe has completed
                if (!buf_if.pop_valid && !q.stb_act)
                begin
                    d.prt       = 1'b0;
                    d.seen_busy = 1'b0;
                    d.st        = ST_PRINT;
                end
            end
            ST_PRINT:
            begin
                if (!ready_s)
                begin
                    d.seen_busy = 1'b1;
                end
                if (q.seen_busy && ready_s)
                begin
                    si_set = 1'b1;
                    d.st   = ST_IDLE;
                end
            end
        endcase

        // Losing power mid-operation abandons it
        if (q.st != ST_IDLE && inop)
        begin
            d.st         = ST_IDLE;
            d.pfd        = 1'b0;
            d.prt        = 1'b0;
            d.inop_latch = 1'b1;
            si_set       = 1'b1;
        end

        // Character strobe engine
        d.stb = 1'b0;
        if (buf_if.pop_ready && buf_if.pop_valid)
        begin
            d.chr     = buf_if.pop_data;
            d.stb_act = 1'b1;
            d.stb_cnt = '0;
        end
        else if (q.stb_act)
        begin
            d.stb_cnt = q.stb_cnt + 4'h1;
            d.stb     = (q.stb_cnt == STB_AT);
            if (q.stb_cnt == STB_DONE)
            begin
                d.stb_act = 1'b0;
            end
        end

        // Buffer-ready edge requests the next word
        d.dready = loading && buf_if.push_ready;
        if (d.dready && !q.dready)
        begin
            di_set = 1'b1;
        end

        // Sets come after clears so a coincident event is kept
        if (si_set && d.si_conn)
        begin
            d.si_pend = 1'b1;
        end
        if (di_set && d.di_conn)
        begin
            d.di_pend = 1'b1;
        end
        d.data_irq = d.di_pend && d.di_conn;
        d.svc_irq  = d.si_pend && d.si_conn;

        if (stat_hit)
        begin
            d.status              = 16'h0000;
            d.status[STS_INOP]    = inop || q.inop_latch;
            d.status[STS_OK]      = !(inop || q.inop_latch);
            d.status[STS_BUSY]    = (q.st != ST_IDLE) || q.held;
            d.status[STS_BUFBUSY] = !q.dready;
            d.status[STS_PLOW]    = q.sync2[PIN_PLOW];
            d.status[STS_BOF]     = q.sync2[PIN_BOF];
            d.status[STS_HOLD]    = hold;
            d.status_valid        = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign status_word    = q.status;
    assign status_valid   = q.status_valid;
    assign data_irq       = q.data_irq;
    assign svc_irq        = q.svc_irq;
    assign paper_feed_cmd = q.pfd;
    assign feed_skip      = q.skip;
    assign feed_lines     = q.lines;
    assign feed_channel   = q.chan;
    assign print_cmd      = q.prt;
    assign data_strobe    = q.stb;
    assign char_out       = q.chr;
endmodule : lpc_top

// file: tb/lpc_top_props.sv
// Port assertions for the line printer controller
`timescale 1ns/1ns
module lpc_top_props
    import lpc_pkg::*;
(
    input wire logic        clk,            // Clock
    input wire logic        reset,          // Async reset
    input wire logic        io_sync,        // Instruction strobe
    input wire logic [15:0] io_instr,       // Instruction word
    input wire logic [15:0] status_word,    // Status
    input wire logic        status_valid,   // Status pulse
    input wire logic        paper_feed_cmd, // Feed request
    input wire logic        feed_skip,      // Skip mode
    input wire logic [5:0]  feed_lines,     // Line count
    input wire logic [7:0]  feed_channel,   // Channel
    input wire logic        print_cmd,      // Print level
    input wire logic        data_strobe     // Char strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic st_hit;
    assign st_hit = io_sync && io_instr[15:10] == OP_STATUS && io_instr[9:8] == OWN_GROUP
        && io_instr[3:0] == OWN_UNIT;
    sequence s_status_req; st_hit; endsequence
    sequence s_strobe_gap; data_strobe ##1 !data_strobe [*4]; endsequence

    a_status_answer: assert property (s_status_req |=> status_valid)
        else $error("status not answered");
    a_status_cause: assert property (status_valid |-> $past(st_hit))
        else $error("status without own request");
    a_unused_zero: assert property (status_valid |-> (status_word & 16'h6E17) == 16'h0000)
        else $error("unused status bit set");
    a_ok_inverse: assert property (status_valid |-> status_word[STS_OK] != status_word[STS_INOP])
        else $error("ok bit not inverse of inoperable");
    a_busy_feed: assert property (status_valid && $past(paper_feed_cmd) |-> status_word[STS_BUSY])
        else $error("busy clear during feed");
    a_strobe_gap: assert property (data_strobe |-> s_strobe_gap)
        else $error("strobe not a single paced pulse");
    a_strobe_print: assert property (data_strobe |-> print_cmd)
        else $error("strobe outside loading");
    a_print_after_feed: assert property ($rose(print_cmd) |-> !paper_feed_cmd)
        else $error("loading before feed done");
    a_skip_fields: assert property (feed_skip |-> feed_lines == 6'h00 && $onehot(feed_channel))
        else $error("bad skip fields");
    a_count_fields: assert property (!feed_skip |-> feed_channel == 8'h00)
        else $error("channel set in line mode");
endmodule : lpc_top_props

bind lpc_top lpc_top_props lpc_top_props_inst (.clk, .reset, .io_sync, .io_instr, .status_word,
    .status_valid, .paper_feed_cmd, .feed_skip, .feed_lines, .feed_channel, .print_cmd,
    .data_strobe);

// file: tb/lpc_printer_model.sv
// Behavioural printer: paper motion and print cycles as ready handshakes
`timescale 1ns/1ns
module lpc_printer_model (
    input  wire logic       clk,            // Clock
    input  wire logic       paper_feed_cmd, // Feed request
    input  wire logic       print_cmd,      // Falling edge prints
    input  wire logic [7:0] dly,            // Motion time in cycles
    output logic            prn_ready,      // Printer ready
    output logic            prn_send_data   // Buffer can take data
);
    logic prev_print;
    initial
    begin
        prn_ready = 1'b1;
        prn_send_data = 1'b1;
        prev_print = 1'b0;
        forever
        begin
            @(posedge clk);
            if ((paper_feed_cmd && prn_ready) || (prev_print && !print_cmd))
            begin
                // Done is shown as ready low then high again
                repeat (3) @(posedge clk);
                prn_ready <= 1'b0;
                repeat (dly) @(posedge clk);
                prn_ready <= 1'b1;
                repeat (4) @(posedge clk);
            end
            prev_print = print_cmd;
        end
    end
endmodule : lpc_printer_model

// file: tb/lpc_top_tb.sv
// Self-checking bench for the line printer controller
`timescale 1ns/1ns
module lpc_top_tb;
    import lpc_pkg::*;
    logic        clk, reset, io_sync, status_valid, data_irq, svc_irq;
    logic        prn_ready, prn_send_data, prn_power_on, prn_stopped, prn_paper_low;
    logic        prn_bottom_form, paper_feed_cmd, feed_skip, print_cmd, data_strobe;
    logic [15:0] io_instr, host_source_register, status_word;
    logic [5:0]  feed_lines;
    logic [7:0]  feed_channel, dly;
    logic [6:0]  char_out;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;

    lpc_top lpc_top_inst (.clk, .reset, .io_sync, .io_instr, .host_source_register,
        .status_word, .status_valid, .data_irq, .svc_irq, .prn_ready, .prn_send_data,
        .prn_power_on, .prn_stopped, .prn_paper_low, .prn_bottom_form, .paper_feed_cmd,
        .feed_skip, .feed_lines, .feed_channel, .print_cmd, .data_strobe, .char_out);
    lpc_printer_model lpc_printer_model_inst (.clk, .paper_feed_cmd, .print_cmd, .dly,
        .prn_ready, .prn_send_data);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic instr(input logic [5:0] op, input logic [1:0] grp, input logic [15:0] src);
        @(posedge clk);
        io_sync <= 1'b1;
        io_instr <= {op, grp, 4'h0, OWN_UNIT};
        host_source_register <= src;
        @(posedge clk);
        io_sync <= 1'b0;
    endtask : instr

    task automatic st_chk(input logic [15:0] exp, input string what);
        instr(OP_STATUS, OWN_GROUP, 16'h0000);
        // Status pulse stands only in the cycle right after the hit
        #1;
        chk({15'h0, status_valid}, 16'h0001, "status pulse");
        // Buffer-busy bit depends on loading phase and is masked out, not checked
        chk(status_word & 16'hFF7F, exp, what);
    endtask : st_chk

    task automatic pins(input logic [3:0] v);
        @(posedge clk);
        {prn_power_on, prn_stopped, prn_paper_low, prn_bottom_form} <= v;
        repeat (4) @(posedge clk);
    endtask : pins

    task automatic t_status();
        st_chk(16'h8000, "idle");
        pins(4'b1011);
        st_chk(16'h8060, "paper low, form");
        pins(4'b1100);
        st_chk(16'h8008, "hold");
        pins(4'b0000);
        st_chk(16'h1000, "power off");
        instr(OP_COMMAND, OWN_GROUP, 16'hD201);
        #1;
        for (int i = 0; i < 10 && !svc_irq; i++) #50;
        chk({15'h0, svc_irq}, 16'h0001, "svc on inoperable");
        pins(4'b1000);
        st_chk(16'h1000, "inoperable latched");
        instr(OP_COMMAND, OWN_GROUP, 16'h4000);
        st_chk(16'h8000, "noop clears");
        chk({15'h0, svc_irq}, 16'h0000, "noop drops svc");
        $display("test status done");
    endtask : t_status

    task automatic do_ctrl(input logic [6:0] f, input logic [15:0] exp);
        instr(OP_COMMAND, OWN_GROUP, {9'h1A4, f});
        #1;
        for (int i = 0; i < 20 && !paper_feed_cmd; i++) #50;
        chk({feed_skip, feed_lines, feed_channel, paper_feed_cmd}, exp | 16'h0001, "feed fields");
        st_chk(16'h8100, "busy");
        #1;
        for (int i = 0; i < 300 && !svc_irq; i++) #50;
        chk({15'h0, svc_irq}, 16'h0001, "svc after motion");
        instr(OP_COMMAND, OWN_GROUP, 16'h4000);
        @(posedge clk);
        #1;
        chk({15'h0, svc_irq}, 16'h0000, "svc cleared");
    endtask : do_ctrl

    task automatic t_ctrl();
        dly = 8'h28;
        do_ctrl(7'h05, 16'h0A00);
        do_ctrl(7'h3F, 16'h7E00);
        dly = 8'h03;
        do_ctrl(7'h40, 16'h8002);
        do_ctrl(7'h47, 16'h8100);
        $display("test control done");
    endtask : t_ctrl

    task automatic t_print();
        instr(OP_COMMAND, OWN_GROUP, 16'hB001);
        #1;
        for (int i = 0; i < 400 && !print_cmd; i++) #50;
        for (int i = 0; i < 5 && !data_irq; i++) #50;
        chk({15'h0, data_irq}, 16'h0001, "first data request");
        for (int k = 0; k < 3; k++)
        begin
            instr(OP_DATA, OWN_GROUP, 16'hFF41 + 16'(k));
            #1;
            for (int i = 0; i < 20 && !data_strobe; i++) #50;
            chk({8'h0, data_strobe, char_out}, 16'h00C1 + 16'(k), "strobe and character");
            repeat (1000) @(posedge clk);
        end
        instr(OP_COMMAND, OWN_GROUP, 16'h0C00);
        #1;
        for (int i = 0; i < 5 && !data_irq; i++) #50;
        chk({15'h0, data_irq}, 16'h0001, "end of block irq");
        for (int i = 0; i < 100 && print_cmd; i++) #50;
        for (int i = 0; i < 300 && !svc_irq; i++) #50;
        chk({14'h0, print_cmd, svc_irq}, 16'h0001, "print then svc");
        instr(OP_COMMAND, OWN_GROUP, 16'h4000);
        @(posedge clk);
        #1;
        chk({14'h0, data_irq, svc_irq}, 16'h0000, "irqs dropped");
        $display("test print done");
    endtask : t_print

    task automatic t_idle();
        instr(OP_COMMAND, OWN_GROUP, 16'h5000);
        instr(OP_COMMAND, OWN_GROUP, 16'h0400);
        #1;
        for (int i = 0; i < 4 && !svc_irq; i++) #50;
        chk({15'h0, svc_irq}, 16'h0001, "idle terminate svc");
        instr(OP_DATA, OWN_GROUP, 16'h0041);
        #1;
        for (int i = 0; i < 20 && !data_strobe; i++) #50;
        chk({15'h0, data_strobe}, 16'h0000, "data after terminate");
        instr(OP_STATUS, 2'h1, 16'h0000);
        #1;
        chk({15'h0, status_valid}, 16'h0000, "foreign group");
        $display("test idle done");
    endtask : t_idle

    initial
    begin
        reset = 1'b1;
        io_sync = 1'b0;
        io_instr = 16'h0000;
        host_source_register = 16'h0000;
        {prn_power_on, prn_stopped, prn_paper_low, prn_bottom_form} = 4'b1000;
        dly = 8'h03;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_status();
        t_ctrl();
        t_print();
        t_idle();
        end_sim();
    end
endmodule : lpc_top_tb
